// file: assw_codec_model.sv
// Purpose: codec side of the serial link for the bench
// Assumes: bit clock of 125 ns, eight bit clocks to a frame
// Notes:   bit clock stands still while i_run is low
`default_nettype none
module assw_codec_model (
   // control from the bench
   input  wire logic       i_run,
   input  wire logic [3:0] i_wake,
   // link pins
   output logic            o_bit_clk,
   output logic            o_frame_sync,
   output logic [3:0]      o_wake_req
);
   timeunit 1ns;
   timeprecision 100ps;
   int n;
   // =========================================================================
   // bit clock and frame marker
   initial begin
      o_bit_clk = 1'b0;
      o_frame_sync = 1'b0;
      n = 0;
      #3;
      forever begin
         #62.5;
         if (i_run) begin
            o_bit_clk = ~o_bit_clk;
            if (o_bit_clk) begin
               n = (n + 1) % 8;
               o_frame_sync = (n == 0);
            end
         end
      end
   end
   // state change request, usable while the link is stopped
   assign o_wake_req = i_wake;
endmodule // assw_codec_model
`default_nettype wire

// file: assw_pkg.sv
// Purpose: shared constants and carrier types for the stream sync and codec wake block
// Assumes: AHB-Lite register window of 32 bytes, word accesses only
// Notes:   streams 0..1 are output streams, 2..3 are input streams
`default_nettype none
package assw_pkg;
   // ==========================================================================
   // sizes
   localparam int NSTR   = 4;
   localparam int NCODEC = 4;
   localparam int CODEC_W = 4;
   localparam int TAG_W   = 6;
   localparam logic [NSTR-1:0] OUT_STREAM_MASK = 4'h3;

   // ==========================================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_WALL   = 8'h04;
   localparam logic [7:0] OFS_HOLD   = 8'h08;
   localparam logic [7:0] OFS_RUN    = 8'h0C;
   localparam logic [7:0] OFS_PRIMED = 8'h10;
   localparam logic [7:0] OFS_CODEC_WAKE_ENABLE = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_UNSOL  = 8'h1C;

   // ==========================================================================
   // field positions
   localparam int CTRL_RST_BIT    = 0;
   localparam int UNSOL_CODEC_LSB = 0;
   localparam int UNSOL_TAG_LSB   = 4;
   localparam int UNSOL_VALID_BIT = 31;

   // ==========================================================================
   // reset values
   localparam logic              RST_CTRL   = 1'b1;
   localparam logic [NSTR-1:0]   RST_HOLD   = 4'h0;
   localparam logic [NSTR-1:0]   RST_RUN    = 4'h0;
   localparam logic [NCODEC-1:0] RST_CODEC_WAKE_ENABLE = 4'h0;
   localparam logic [31:0]       RST_WALL   = 32'h0000_0000;
   localparam logic [31:0]       WALL_STEP  = 32'h0000_0001;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } assw_ahb_req_t;

   typedef struct packed {
      logic               valid;
      logic [CODEC_W-1:0] codec;
      logic [TAG_W-1:0]   tag;
   } assw_unsol_t;
endpackage
`default_nettype wire

// file: assw_properties.sv
// Purpose: port-level checks for assw_top
// Assumes: i_clk_en held high
// Notes:   frame bound covers the pin synchronisers
`default_nettype none
module assw_properties
   import assw_pkg::*;
(
   input wire logic            i_sys_clk,
   input wire logic            i_reset,
   input wire assw_ahb_req_t   i_ahb,
   input wire logic            o_hreadyout,
   input wire logic            o_hresp,
   input wire logic [31:0]     o_hrdata,
   input wire logic            i_frame_sync,
   input wire logic            o_link_run,
   input wire logic [NSTR-1:0] o_dma_fetch_en,
   input wire logic [NSTR-1:0] o_link_xfer_en,
   input wire logic            i_sys_s3,
   input wire logic            i_d3_exit,
   input wire logic            o_pme
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   logic [7:0] since_fs_r;
   logic       fs_d_r;
   // cycles since the last frame start
   always_ff @(posedge i_sys_clk) begin
      fs_d_r <= i_frame_sync;
      if (i_reset) since_fs_r <= 8'hFF;
      else if (i_frame_sync && !fs_d_r) since_fs_r <= 8'h00;
      else if (since_fs_r != 8'hFF) since_fs_r <= since_fs_r + 8'h01;
   end
   // =========================================================================
   // sequences and properties
   sequence s_rd;
      i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1] && o_hreadyout && !i_ahb.hwrite;
   endsequence
   sequence s_wr;
      i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1] && o_hreadyout && i_ahb.hwrite;
   endsequence
   sequence s_ctrl_clear;
      (s_wr and (i_ahb.haddr[7:0] == OFS_CTRL)) ##1 !i_ahb.hwdata[0];
   endsequence
   property p_rd_wait; s_rd |=> !o_hreadyout ##1 o_hreadyout; endproperty
   property p_wr_nowait; s_wr |=> o_hreadyout; endproperty
   property p_okay; o_hresp == 1'b0; endproperty
   property p_rdata_hold; o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata); endproperty
   property p_link_up; s_ctrl_clear |-> ##[1:2] o_link_run; endproperty
   property p_xfer_frame;
      $changed(o_link_xfer_en) && $past(o_link_run) && o_link_run |-> since_fs_r <= 8'd10;
   endproperty
   property p_xfer_run;
      (o_link_xfer_en & ~$past(o_link_xfer_en) & ~$past(o_dma_fetch_en)) == 4'h0;
   endproperty
   property p_pme_s3; o_pme |-> $past(i_sys_s3); endproperty
   property p_d3_stop; i_d3_exit |-> ##[1:2] (o_dma_fetch_en == 4'h0 && !o_link_run); endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   a_link_up: assert property (p_link_up) else $error("link not up");
   a_xfer_frame: assert property (p_xfer_frame) else $error("xfer off frame");
   a_xfer_run: assert property (p_xfer_run) else $error("xfer without run");
   a_pme_s3: assert property (p_pme_s3) else $error("pme outside s3");
   a_d3_stop: assert property (p_d3_stop) else $error("d3 exit kept run");
endmodule // assw_properties
bind assw_top assw_properties u_props (.i_sys_clk, .i_reset, .i_ahb, .o_hreadyout, .o_hresp,
   .o_hrdata, .i_frame_sync, .o_link_run, .o_dma_fetch_en, .o_link_xfer_en, .i_sys_s3,
   .i_d3_exit, .o_pme);
`default_nettype wire

// file: assw_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to i_sys_clk
// Notes:   output follows only once stages two and three agree
`default_nettype none
module assw_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_reset,
   input  wire logic         i_clk_en,
   // data
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_stable
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } assw_sync_state_t;

   assw_sync_state_t st_r;
   assw_sync_state_t st_nxt;

   always_comb begin
      st_nxt        = st_r;
      st_nxt.s1     = i_async;
      st_nxt.s2     = st_r.s1;
      st_nxt.s3     = st_r.s2;
      // change taken only where the two later stages agree
      st_nxt.stable = (st_r.s2 & st_r.s3) | (st_r.stable & (st_r.s2 | st_r.s3));
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         st_r <= '0;
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign o_stable = st_r.stable;
endmodule // assw_sync
`default_nettype wire

// file: assw_top.sv
// Purpose: wall clock, synchronised stream start/stop and codec wake for the link controller
// Assumes: AHB-Lite slave, word accesses; bit clock and frame sync sampled as pins
// Notes:   reads take one wait state, writes none; response always OKAY
//
// Summary of operation
// - A 32-bit ever-increasing wall clock is readable by software.
// - The wall clock advances only while the link bit clock toggles.
// - Run with hold set: DMA fetches, but link transfer stays paused.
// - Initialization clears every run bit and every hold bit.
// - Output stream primed flag rises once enough sample data is fetched.
// - Input stream primed flag is 1 when any input descriptor is available.
// - Output stream sends its first sample the frame after hold clears.
// - Input stream captures data from the frame after hold clears.
// - Writing 1 to hold stops running streams at the next frame start.
// - Leaving D3 for D0 keeps only resume-retained registers.
// - The controller reset bit stops controller and link as one unit.
// - In D3 with reset bit 1 the link stays stopped; codecs request on link.
// - Per-codec state-change requests are recorded, readable during reset.
// - In S3 an enabled codec request is forwarded to power management.
// - In S0/D0 the source codec and tag of unsolicited responses are shown.
// - Cleared run: finish frame, stop next frame, read 0 once DMA idles.
// - Re-run resumes the DMA from the buffer position where it stopped.
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
module assw_top
   import assw_pkg::*;
(
   // clock, enable, reset
   input  wire logic               i_sys_clk,
   input  wire logic               i_clk_en,
   input  wire logic               i_reset,
   // ahb-lite slave
   input  wire assw_ahb_req_t      i_ahb,
   output logic                    o_hreadyout,
   output logic                    o_hresp,
   output logic        [31:0]      o_hrdata,
   // link pins
   input  wire logic               i_bit_clk,
   input  wire logic               i_frame_sync,
   input  wire logic [NCODEC-1:0]  i_codec_wake_req,
   output logic                    o_link_run,
   // stream dma engines
   input  wire logic [NSTR-1:0]    i_out_data_ready,
   input  wire logic [NSTR-1:0]    i_in_desc_avail,
   input  wire logic [NSTR-1:0]    i_dma_idle,
   output logic      [NSTR-1:0]    o_dma_fetch_en,
   output logic      [NSTR-1:0]    o_link_xfer_en,
   // response engine and power management
   input  wire assw_unsol_t        i_unsol,
   input  wire logic               i_sys_s3,
   input  wire logic               i_d3_exit,
   output logic                    o_pme
);
   // ==========================================================================
   // state
   typedef struct packed {
      logic                   hready;
      logic [31:0]            hrdata;
      logic                   rd_pend;
      logic                   wr_pend;
      logic [7:0]             addr;
      logic                   ctrl_rst;
      logic                   link_run;
      logic [31:0]            wall;
      logic [NSTR-1:0]        hold;
      logic [NSTR-1:0]        run_req;
      logic [NSTR-1:0]        run_act;
      logic [NSTR-1:0]        xfer_en;
      logic [NSTR-1:0]        primed;
      logic [NCODEC-1:0]      codec_wake_enable;
      logic [NCODEC-1:0]      codec_state_change_status;
      logic                   unsol_valid;
      logic [CODEC_W-1:0]     unsol_codec;
      logic [TAG_W-1:0]       unsol_tag;
      logic                   pme;
      logic                   bclk_q;
      logic                   fsync_q;
      logic [NCODEC-1:0]      wake_q;
   } assw_state_t;

   localparam assw_state_t ST_RST = '{
      hready:   1'b1,
      ctrl_rst: RST_CTRL,
      wall:     RST_WALL,
      hold:     RST_HOLD,
      run_req:  RST_RUN,
      run_act:  RST_RUN,
      codec_wake_enable:   RST_CODEC_WAKE_ENABLE,
      default:  '0
   };

   assw_state_t             st_r;
   assw_state_t             st_nxt;
   logic [NCODEC+1:0]       pins_sync;
   logic                    bclk_rise;
   logic                    fsync_rise;
   logic [NCODEC-1:0]       wake_rise;
   logic                    addr_take;

   // ==========================================================================
   // pin synchronisers
   assw_sync #(
      .W (NCODEC + 2)
   ) u_pins (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clk_en  (i_clk_en),
      .i_async   ({i_codec_wake_req, i_frame_sync, i_bit_clk}),
      .o_stable  (pins_sync)
   );

   assign bclk_rise  = pins_sync[0] & ~st_r.bclk_q;
   assign fsync_rise = pins_sync[1] & ~st_r.fsync_q;
   assign wake_rise  = pins_sync[NCODEC+1:2] & ~st_r.wake_q;
   assign addr_take  = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1] & st_r.hready;

   // ==========================================================================
   // read decode
   function automatic logic [31:0] rd_word(input assw_state_t s, input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case ({a[7:2], 2'b00})
         OFS_CTRL:   w[CTRL_RST_BIT] = s.ctrl_rst;
         OFS_WALL:   w = s.wall;
         OFS_HOLD:   w[NSTR-1:0] = s.hold;
         OFS_RUN:    w[NSTR-1:0] = s.run_act;
         OFS_PRIMED: w[NSTR-1:0] = s.primed;
         OFS_CODEC_WAKE_ENABLE: w[NCODEC-1:0] = s.codec_wake_enable;
         OFS_STATUS: w[NCODEC-1:0] = s.codec_state_change_status;
         OFS_UNSOL: begin
            w[UNSOL_VALID_BIT] = s.unsol_valid;
            w[UNSOL_CODEC_LSB +: CODEC_W] = s.unsol_codec;
            w[UNSOL_TAG_LSB +: TAG_W] = s.unsol_tag;
         end
         default:    w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // ==========================================================================
   // next state
   always_comb begin
      st_nxt         = st_r;
      st_nxt.bclk_q  = pins_sync[0];
      st_nxt.fsync_q = pins_sync[1];
      st_nxt.wake_q  = pins_sync[NCODEC+1:2];

      // wall clock: counts bit clock rising edges only, wraps without event
      if (bclk_rise) begin
         st_nxt.wall = st_r.wall + WALL_STEP;
      end

      // codec requests recorded even while the controller is held in reset
      st_nxt.codec_state_change_status = st_r.codec_state_change_status | wake_rise;

      // bus: address phase capture
      st_nxt.wr_pend = 1'b0;
      st_nxt.rd_pend = 1'b0;
      if (st_r.rd_pend) begin
         st_nxt.hrdata = rd_word(st_r, st_r.addr);
         st_nxt.hready = 1'b1;
         if ({st_r.addr[7:2], 2'b00} == OFS_UNSOL) begin
            st_nxt.unsol_valid = 1'b0;
         end
      end
      if (addr_take) begin
         st_nxt.addr = i_ahb.haddr[7:0];
         if (i_ahb.hwrite) begin
            st_nxt.wr_pend = 1'b1;
         end else begin
            st_nxt.rd_pend = 1'b1;
            st_nxt.hready  = 1'b0;
         end
      end

      // bus: write data phase
      if (st_r.wr_pend) begin
         unique case ({st_r.addr[7:2], 2'b00})
            OFS_CTRL:   st_nxt.ctrl_rst = i_ahb.hwdata[CTRL_RST_BIT];
            OFS_HOLD:   st_nxt.hold = i_ahb.hwdata[NSTR-1:0];
            OFS_RUN: begin
               st_nxt.run_req = i_ahb.hwdata[NSTR-1:0];
               st_nxt.run_act = st_r.run_act | i_ahb.hwdata[NSTR-1:0];
            end
            OFS_CODEC_WAKE_ENABLE: st_nxt.codec_wake_enable = i_ahb.hwdata[NCODEC-1:0];
            OFS_STATUS: begin
               // write one clears; a request in the same cycle wins
               st_nxt.codec_state_change_status = (st_r.codec_state_change_status & ~i_ahb.hwdata[NCODEC-1:0]) | wake_rise;
            end
            default: begin
            end
         endcase
      end

      // link gating changes only at a frame start or when the reset bit clears it
      if (fsync_rise) begin
         st_nxt.xfer_en = st_r.run_req & ~st_r.hold;
      end

      // run reads back 0 only after the link has stopped and the dma idles, or at once while the reset bit is set
      for (int i = 0; i < NSTR; i++) begin
         if (!st_nxt.run_req[i] && !st_r.xfer_en[i] && i_dma_idle[i]) begin
            st_nxt.run_act[i] = 1'b0;
         end
         if (OUT_STREAM_MASK[i]) begin
            st_nxt.primed[i] = st_r.run_req[i] & i_out_data_ready[i];
         end else begin
            st_nxt.primed[i] = st_r.run_req[i] & i_in_desc_avail[i];
         end
      end

      // unsolicited response capture only in S0 with the link up
      if (i_unsol.valid && st_r.link_run && !i_sys_s3) begin
         st_nxt.unsol_valid = 1'b1;
         st_nxt.unsol_codec = i_unsol.codec;
         st_nxt.unsol_tag   = i_unsol.tag;
      end

      // enabled requests routed to power management while asleep
      st_nxt.pme = i_sys_s3 & |(st_r.codec_state_change_status & st_r.codec_wake_enable);

      // leaving D3: the wake enables, status and wall clock survive
      if (i_d3_exit) begin
         st_nxt.ctrl_rst    = RST_CTRL;
         st_nxt.hold        = RST_HOLD;
         st_nxt.run_req     = RST_RUN;
         st_nxt.unsol_valid = 1'b0;
      end

      // controller reset bit takes streams and link down together
      if (st_nxt.ctrl_rst) begin
         st_nxt.run_req     = RST_RUN;
         st_nxt.run_act     = RST_RUN;
         st_nxt.hold        = RST_HOLD;
         st_nxt.xfer_en     = '0;
         st_nxt.primed      = '0;
         st_nxt.unsol_valid = 1'b0;
      end
      st_nxt.link_run = ~st_nxt.ctrl_rst;
   end

   // ==========================================================================
   // state register
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         st_r <= ST_RST;
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================================
   // outputs
   assign o_hreadyout    = st_r.hready;
   assign o_hresp        = 1'b0;
   assign o_hrdata       = st_r.hrdata;
   assign o_link_run     = st_r.link_run;
   // position is kept inside the dma; only fetch permission is gated here
   assign o_dma_fetch_en = st_r.run_req;
   assign o_link_xfer_en = st_r.xfer_en;
   assign o_pme          = st_r.pme;
endmodule // assw_top
`default_nettype wire

// file: testbench.sv
// Purpose: register-level tests of assw_top
// Assumes: reads take one wait state
// Notes:   codec model makes bit clock and frames
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module testbench
   import assw_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst = 1'b1, brun = 1'b0, s3 = 1'b0, d3x = 1'b0;
   logic hrdy, hresp, lrun, pme, bclk, fsync;
   logic [31:0] hrdata, rd, w0;
   logic [3:0] wake, wreq, rdy, desc, idle, fetch, xfer;
   assw_ahb_req_t m, ahb;
   assw_unsol_t unsol;
   int n_mismatch = 0, compares = 0, cyc = 0;
   always #5 clk = ~clk;
   always_comb begin
      ahb = m;
      ahb.hready = hrdy;
   end
   assw_top dut (.i_sys_clk(clk), .i_clk_en(1'b1), .i_reset(rst), .i_ahb(ahb),
      .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_bit_clk(bclk),
      .i_frame_sync(fsync), .i_codec_wake_req(wreq), .o_link_run(lrun),
      .i_out_data_ready(rdy), .i_in_desc_avail(desc), .i_dma_idle(idle),
      .o_dma_fetch_en(fetch), .o_link_xfer_en(xfer), .i_unsol(unsol), .i_sys_s3(s3),
      .i_d3_exit(d3x), .o_pme(pme));
   assw_codec_model u_codec (.i_run(brun), .i_wake(wake), .o_bit_clk(bclk),
      .o_frame_sync(fsync), .o_wake_req(wreq));
   // =========================================================================
   // bus and check tasks
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      m.hsel <= 1'b1;
      m.haddr <= {24'h000000, a};
      m.htrans <= 2'h2;
      m.hwrite <= wr;
      m.hsize <= 3'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      m.htrans <= 2'h0;
      m.hsel <= 1'b0;
      m.hwdata <= wd;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask
   task automatic wfr;
      @(posedge fsync);
      repeat (12) @(posedge clk);
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         results();
      end
   end
   // =========================================================================
   // tests
   initial begin
      m = '0;
      unsol = '0;
      wake = 4'h0;
      rdy = 4'h0;
      desc = 4'h0;
      idle = 4'hF;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk("ctrl", OFS_CTRL, 32'h1);
      `CHK("link down", 1'b0, lrun)
      rchk("hold", OFS_HOLD, 32'h0);
      rchk("run", OFS_RUN, 32'h0);
      rchk("unmapped", 8'h20, 32'h0);
      bus(1'b1, OFS_RUN, 32'hF);
      rchk("run ignored", OFS_RUN, 32'h0);
      $display("test reset done");
      bus(1'b1, OFS_CODEC_WAKE_ENABLE, 32'h5);
      s3 <= 1'b1;
      wake <= 4'h3;
      repeat (10) @(posedge clk);
      wake <= 4'h0;
      rchk("status", OFS_STATUS, 32'h3);
      `CHK("pme on", 1'b1, pme)
      bus(1'b1, OFS_STATUS, 32'h1);
      repeat (3) @(posedge clk);
      `CHK("pme off", 1'b0, pme)
      rchk("status w1c", OFS_STATUS, 32'h2);
      s3 <= 1'b0;
      $display("test wake done");
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b0, OFS_WALL, 32'h0);
      w0 = rd;
      `CHK("link up", 1'b1, lrun)
      repeat (50) @(posedge clk);
      rchk("wall still", OFS_WALL, w0);
      brun <= 1'b1;
      repeat (100) @(posedge clk);
      bus(1'b0, OFS_WALL, 32'h0);
      `CHK("wall step", 1'b1, (rd - w0 >= 6 && rd - w0 <= 10))
      $display("test wall done");
      bus(1'b1, OFS_HOLD, 32'hF);
      bus(1'b1, OFS_RUN, 32'hF);
      rchk("primed none", OFS_PRIMED, 32'h0);
      rdy <= 4'h3;
      desc <= 4'hC;
      idle <= 4'h0;
      @(posedge clk);
      rchk("primed", OFS_PRIMED, 32'hF);
      `CHK("fetch on", 4'hF, fetch)
      wfr;
      `CHK("paused", 4'h0, xfer)
      bus(1'b1, OFS_HOLD, 32'h0);
      `CHK("held to frame", 4'h0, xfer)
      wfr;
      `CHK("flowing", 4'hF, xfer)
      bus(1'b1, OFS_HOLD, 32'hF);
      `CHK("mid frame", 4'hF, xfer)
      wfr;
      `CHK("stopped", 4'h0, xfer)
      bus(1'b1, OFS_RUN, 32'h0);
      rchk("run busy", OFS_RUN, 32'hF);
      idle <= 4'hF;
      @(posedge clk);
      rchk("run idle", OFS_RUN, 32'h0);
      bus(1'b1, OFS_HOLD, 32'h0);
      bus(1'b1, OFS_RUN, 32'h3);
      @(posedge clk);
      `CHK("rerun", 4'h3, fetch)
      $display("test streams done");
      unsol <= '{1'b1, 4'h2, 6'h15};
      @(posedge clk);
      unsol <= '0;
      rchk("unsol", OFS_UNSOL, 32'h8000_0152);
      bus(1'b0, OFS_UNSOL, 32'h0);
      `CHK("unsol clear", 1'b0, rd[31])
      `CHK("okay", 1'b0, hresp)
      bus(1'b1, OFS_HOLD, 32'hA);
      d3x <= 1'b1;
      @(posedge clk);
      d3x <= 1'b0;
      repeat (3) @(posedge clk);
      rchk("d3 ctrl", OFS_CTRL, 32'h1);
      `CHK("d3 link", 1'b0, lrun)
      rchk("d3 hold", OFS_HOLD, 32'h0);
      rchk("d3 codec_wake_enable", OFS_CODEC_WAKE_ENABLE, 32'h5);
      rchk("d3 status", OFS_STATUS, 32'h2);
      bus(1'b1, OFS_CODEC_WAKE_ENABLE, 32'h5);
      rchk("d3 requery", OFS_STATUS, 32'h2);
      $display("test d3 done");
      results();
   end
endmodule // testbench
`default_nettype wire
